// file: design/timer_two_pkg.sv
// Purpose: shared constants for the auto-reload timer
// Assumes: 32-bit classic wishbone, byte addresses
// Notes:   8-bit registers sit in the low byte lane
package timer_two_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL   = 8'h00;
    localparam logic [7:0] OFS_RELOAD_LO = 8'h04;
    localparam logic [7:0] OFS_RELOAD_HI = 8'h08;
    localparam logic [7:0] OFS_COUNT_LO  = 8'h0c;
    localparam logic [7:0] OFS_COUNT_HI  = 8'h10;
    localparam logic [7:0] OFS_CLOCK_CTL = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h18;

    // timer_control_reg fields
    localparam int unsigned BIT_HIGH_OVF   = 7;
    localparam int unsigned BIT_LOW_OVF    = 6;
    localparam int unsigned BIT_LOW_IRQ_EN = 5;
    localparam int unsigned BIT_LF_CAPTURE = 4;
    localparam int unsigned BIT_SPLIT      = 3;
    localparam int unsigned BIT_RUN        = 2;
    localparam int unsigned BIT_UNUSED     = 1;
    localparam int unsigned BIT_EXT_CLK    = 0;

    // clock_control_reg fields
    localparam int unsigned BIT_HIGH_CLK_SEL = 5;
    localparam int unsigned BIT_LOW_CLK_SEL  = 4;

    // irq enable register field
    localparam int unsigned BIT_TIMER_IRQ_EN = 5;

    // writable masks and reset values
    localparam logic [7:0] CONTROL_MASK   = 8'hfd;
    localparam logic [7:0] CLOCK_CTL_MASK = 8'h30;
    localparam logic [7:0] IRQ_EN_MASK    = 8'h20;
    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [7:0] RELOAD_RESET   = 8'h00;
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [7:0] CLOCK_RESET    = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET   = 8'h00;
    localparam logic [7:0] BYTE_MAX       = 8'hff;

    // clock dividers
    localparam int unsigned CORE_DIV = 12;
    localparam int unsigned EXT_DIV  = 8;
endpackage

// file: design/timer_two_ticks.sv
// Purpose: count-enable pulses for the timer clock sources
// Assumes: ext_osc_i is free running and slower than clk_i/2
// Notes:   ext_osc_i is resynchronised before edge detection
`timescale 1ns/1ps
module timer_two_ticks #(
    parameter int unsigned CORE_DIV = timer_two_pkg::CORE_DIV,
    parameter int unsigned EXT_DIV  = timer_two_pkg::EXT_DIV
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ext_osc_i,
    output logic      div12_tick_o,
    output logic      ext8_tick_o
);
    logic [3:0] core_cnt;
    logic [2:0] ext_cnt;
    logic       ext_meta;
    logic       ext_sync;
    logic       ext_prev;
    wire        ext_rise  = ext_sync & ~ext_prev;
    wire        core_last = (core_cnt == 4'(CORE_DIV - 1));
    wire        ext_last  = (ext_cnt == 3'(EXT_DIV - 1));

    // core clock divided by twelve
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_cnt     <= 4'h0;
            div12_tick_o <= 1'b0;
        end else begin
            core_cnt     <= core_last ? 4'h0 : core_cnt + 4'h1;
            div12_tick_o <= core_last;
        end
    end

    // two-flop synchroniser, then divide rising edges by eight
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_meta    <= 1'b0;
            ext_sync    <= 1'b0;
            ext_prev    <= 1'b0;
            ext_cnt     <= 3'h0;
            ext8_tick_o <= 1'b0;
        end else begin
            ext_meta    <= ext_osc_i;
            ext_sync    <= ext_meta;
            ext_prev    <= ext_sync;
            if (ext_rise) begin
                ext_cnt <= ext_last ? 3'h0 : ext_cnt + 3'h1;
            end
            ext8_tick_o <= ext_rise & ext_last;
        end
    end

    a_div12_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        div12_tick_o |=> !div12_tick_o [*8])
        else $error("divide-by-12 tick repeated too soon");
endmodule

// file: design/timer_two.sv
// Purpose: auto-reload timer, 16-bit or two 8-bit counters
// Assumes: classic wishbone slave, one wait state per access
// Notes:   irq_o is a level request to the interrupt logic
// Contract
// - count made of two 8-bit byte registers
// - control bit 3 selects split mode
// - sources: core, core/12, external/8
// - external divided clock synchronised to core
// - 16-bit wrap reloads, sets high flag
// - 16-bit overflow requests interrupt when enabled
// - low wrap interrupts when low enable set
// - split bytes reload from own reload
// - split: run gates high byte only
// - split byte clock from its select bit
// - split wraps set high and low flags
// - split high overflow requests interrupt
// - split either overflow with low enable
// - hardware never clears overflow flags
// - high clock select: one means core clock
// - high select zero follows external select
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module timer_two (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ext_osc_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             irq_o
);
    logic [7:0] timer_control_reg;
    logic [7:0] clock_control_reg;
    logic [7:0] irq_enable_reg;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic       div12_tick;
    logic       ext8_tick;

    timer_two_ticks u_ticks (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ext_osc_i    (ext_osc_i),
        .div12_tick_o (div12_tick),
        .ext8_tick_o  (ext8_tick)
    );

    // control fields
    wire split_mode_select      =
        timer_control_reg[timer_two_pkg::BIT_SPLIT];
    wire run_control            =
        timer_control_reg[timer_two_pkg::BIT_RUN];
    wire ext_clock_select       =
        timer_control_reg[timer_two_pkg::BIT_EXT_CLK];
    wire low_byte_irq_enable    =
        timer_control_reg[timer_two_pkg::BIT_LOW_IRQ_EN];
    wire high_overflow_flag     =
        timer_control_reg[timer_two_pkg::BIT_HIGH_OVF];
    wire low_overflow_flag      =
        timer_control_reg[timer_two_pkg::BIT_LOW_OVF];
    wire high_byte_clock_select =
        clock_control_reg[timer_two_pkg::BIT_HIGH_CLK_SEL];
    wire low_byte_clock_select  =
        clock_control_reg[timer_two_pkg::BIT_LOW_CLK_SEL];
    wire timer_irq_enable       =
        irq_enable_reg[timer_two_pkg::BIT_TIMER_IRQ_EN];

    // bus decode: a write lands on the edge that sees ack high
    wire req       = cyc_i & stb_i;
    wire wr        = req & we_i & ack_o & sel_i[0];
    wire hit_ctrl  = (adr_i == timer_two_pkg::OFS_CONTROL);
    wire hit_rl_lo = (adr_i == timer_two_pkg::OFS_RELOAD_LO);
    wire hit_rl_hi = (adr_i == timer_two_pkg::OFS_RELOAD_HI);
    wire hit_cn_lo = (adr_i == timer_two_pkg::OFS_COUNT_LO);
    wire hit_cn_hi = (adr_i == timer_two_pkg::OFS_COUNT_HI);
    wire hit_clock_control_reg = (adr_i == timer_two_pkg::OFS_CLOCK_CTL);
    wire hit_irqen = (adr_i == timer_two_pkg::OFS_IRQ_EN);
    wire wr_ctrl   = wr & hit_ctrl;
    wire wr_cn_lo  = wr & hit_cn_lo;
    wire wr_cn_hi  = wr & hit_cn_hi;
    wire [7:0] wdat = dat_i[7:0];

    wire [7:0] rd_byte =
        hit_ctrl  ? timer_control_reg :
        hit_rl_lo ? reload_low_byte   :
        hit_rl_hi ? reload_high_byte  :
        hit_cn_lo ? count_low_byte    :
        hit_cn_hi ? count_high_byte   :
        hit_clock_control_reg ? clock_control_reg :
        hit_irqen ? irq_enable_reg    : 8'h00;

    // count enables per byte
    wire src_tick   = ext_clock_select ? ext8_tick : div12_tick;
    wire tick_high  = high_byte_clock_select ? 1'b1 : src_tick;
    wire tick_low   = low_byte_clock_select ? 1'b1 : src_tick;
    wire lo_max     = (count_low_byte == timer_two_pkg::BYTE_MAX);
    wire hi_max     = (count_high_byte == timer_two_pkg::BYTE_MAX);
    wire adv16      = ~split_mode_select & run_control & tick_low;
    wire adv_lo8    = split_mode_select & tick_low;
    wire adv_hi8    = split_mode_select & run_control & tick_high;
    wire adv_lo     = adv16 | adv_lo8;
    wire adv_hi     = (adv16 & lo_max) | adv_hi8;
    wire wrap16     = adv16 & lo_max & hi_max;
    wire low_wrap   = adv_lo & lo_max;
    wire high_wrap  = adv_hi & hi_max;
    wire [7:0] lo_plus = count_low_byte + 8'h01;
    wire [7:0] hi_plus = count_high_byte + 8'h01;

    logic [7:0] next_count_low;
    logic [7:0] next_count_high;
    assign next_count_low  =
        wr_cn_lo ? wdat :
        !adv_lo  ? count_low_byte :
        (wrap16 | (adv_lo8 & lo_max)) ? reload_low_byte :
        lo_plus;
    assign next_count_high =
        wr_cn_hi  ? wdat :
        !adv_hi   ? count_high_byte :
        high_wrap ? reload_high_byte :
        hi_plus;

    // hardware set wins over a clearing write
    wire set_high = high_wrap;
    wire set_low  = low_wrap;
    logic [7:0] next_control;
    assign next_control =
        ((wr_ctrl ? (wdat & timer_two_pkg::CONTROL_MASK)
                  : timer_control_reg)
         | ({7'h00, set_high} << timer_two_pkg::BIT_HIGH_OVF)
         | ({7'h00, set_low} << timer_two_pkg::BIT_LOW_OVF));

    wire next_irq = timer_irq_enable &
        (high_overflow_flag | (low_byte_irq_enable & low_overflow_flag));

    // bus slave
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req & ~ack_o;
            dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reload_low_byte   <= timer_two_pkg::RELOAD_RESET;
            reload_high_byte  <= timer_two_pkg::RELOAD_RESET;
            clock_control_reg <= timer_two_pkg::CLOCK_RESET;
            irq_enable_reg    <= timer_two_pkg::IRQ_EN_RESET;
        end else begin
            if (wr & hit_rl_lo) begin
                reload_low_byte <= wdat;
            end
            if (wr & hit_rl_hi) begin
                reload_high_byte <= wdat;
            end
            if (wr & hit_clock_control_reg) begin
                clock_control_reg <= wdat & timer_two_pkg::CLOCK_CTL_MASK;
            end
            if (wr & hit_irqen) begin
                irq_enable_reg <= wdat & timer_two_pkg::IRQ_EN_MASK;
            end
        end
    end

    // counters, flags and request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_control_reg <= timer_two_pkg::CONTROL_RESET;
            count_low_byte    <= timer_two_pkg::COUNT_RESET;
            count_high_byte   <= timer_two_pkg::COUNT_RESET;
            irq_o             <= 1'b0;
        end else begin
            timer_control_reg <= next_control;
            count_low_byte    <= next_count_low;
            count_high_byte   <= next_count_high;
            irq_o             <= next_irq;
        end
    end

    // software clears flags only by an explicit write

    sequence s_wrap16;
        wrap16 && !wr_cn_lo && !wr_cn_hi;
    endsequence

    sequence s_reloaded16;
        count_low_byte == $past(reload_low_byte) &&
        count_high_byte == $past(reload_high_byte) &&
        high_overflow_flag;
    endsequence

    a_wrap16_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wrap16 |=> s_reloaded16)
        else $error("16-bit wrap did not reload and flag");

    a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        high_overflow_flag && !wr_ctrl |=> high_overflow_flag)
        else $error("high overflow flag cleared by hardware");

    a_low_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        low_overflow_flag && !wr_ctrl |=> low_overflow_flag)
        else $error("low overflow flag cleared by hardware");

    a_hold_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
        !split_mode_select && !run_control && !wr_cn_lo && !wr_cn_hi
        |=> $stable(count_low_byte) && $stable(count_high_byte))
        else $error("16-bit count moved while stopped");

    a_split_low_runs: assert property (@(posedge clk_i) disable iff (rst_i)
        split_mode_select && !run_control && low_byte_clock_select &&
        !wr_cn_lo && !(lo_max && reload_low_byte == timer_two_pkg::BYTE_MAX)
        |=> count_low_byte != $past(count_low_byte))
        else $error("split low byte did not run");

    a_split_high_gated: assert property (@(posedge clk_i)
        disable iff (rst_i)
        split_mode_select && !run_control && !wr_cn_hi
        |=> $stable(count_high_byte))
        else $error("split high byte ran while stopped");

    a_split_lo_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        adv_lo8 && lo_max && !wr_cn_lo
        |=> count_low_byte == $past(reload_low_byte)
            && low_overflow_flag)
        else $error("split low byte reload or flag missing");

    a_irq_high: assert property (@(posedge clk_i) disable iff (rst_i)
        high_wrap && timer_irq_enable && !wr_ctrl
        |=> ##1 irq_o)
        else $error("overflow gave no interrupt request");

    a_irq_low_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !high_overflow_flag && !low_byte_irq_enable |=> !irq_o)
        else $error("interrupt without enabled cause");

    a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && hit_ctrl |-> !dat_o[timer_two_pkg::BIT_UNUSED])
        else $error("unused control bit read as one");

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
endmodule

// file: tb/tb_timer_two.sv
// Purpose: self-checking bench for the auto-reload timer
// Assumes: classic wishbone master, ack sampled at rising edge
// Notes:   reads queue {addr, tolerance, value}; a monitor compares
`timescale 1ns/1ps
module tb_timer_two;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ext_osc_i = 1'b0;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h1;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        irq_o;
    logic [23:0] exp_q[$];
    logic [23:0] e;
    logic [7:0]  r;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          seed = 32'h8acd;
    logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                             8'h18, 8'h1c};

    timer_two timer_two_inst (.clk_i(clk_i), .rst_i(rst_i),
        .ext_osc_i(ext_osc_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .irq_o(irq_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // external oscillator, ten core clocks a period
    initial begin
        forever begin
            repeat (5) @(posedge clk_i);
            ext_osc_i <= ~ext_osc_i;
        end
    end

    task automatic end_of_test();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v,
                      input logic [7:0] tol);
        exp_q.push_back({a, tol, v});
        wb(1'b0, a, 8'h00);
    endtask

    task automatic chk_data(input logic [23:0] x);
        int g;
        int v;
        g = int'(dat_o[7:0]);
        v = int'(x[7:0]);
        samples_checked++;
        if ((^dat_o === 1'bx) || dat_o[31:8] !== 24'h0 ||
            g < v - int'(x[15:8]) || g > v + int'(x[15:8])) begin
            $display("[FAIL] reg 0x%h exp %h got %h", x[23:16], x[7:0],
                     dat_o);
            n_errors++;
        end
    endtask

    task automatic chk_irq(input logic v);
        repeat (3) @(posedge clk_i);
        samples_checked++;
        if (irq_o !== v) begin
            $display("[FAIL] irq_o exp %b got %b", v, irq_o);
            n_errors++;
        end
    endtask

    // read monitor
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk_data(e);
        end
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 8'h00, 8'h00);
        wb(1'b1, 8'h00, 8'h02);
        rd(8'h00, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = 8'($random(seed));
            for (int k = 1; k < 5; k++) wb(1'b1, ofs[k], r + 8'(k));
            sel_i <= 4'h0;
            wb(1'b1, 8'h0c, ~r);
            sel_i <= 4'h1;
            repeat (30) @(posedge clk_i);
            for (int k = 1; k < 5; k++) rd(ofs[k], r + 8'(k), 8'h00);
        end
        // 16-bit wrap with reload
        wb(1'b1, 8'h04, 8'h34);
        wb(1'b1, 8'h08, 8'h12);
        wb(1'b1, 8'h14, 8'h10);
        wb(1'b1, 8'h0c, 8'hfe);
        wb(1'b1, 8'h10, 8'hff);
        wb(1'b1, 8'h00, 8'h04);
        repeat (10) @(posedge clk_i);
        rd(8'h00, 8'hc4, 8'h00);
        rd(8'h10, 8'h12, 8'h00);
        chk_irq(1'b0);
        wb(1'b1, 8'h18, 8'h20);
        chk_irq(1'b1);
        repeat (50) @(posedge clk_i);
        rd(8'h00, 8'hc4, 8'h00);
        wb(1'b1, 8'h00, 8'h04);
        chk_irq(1'b0);
        wb(1'b1, 8'h00, 8'h24);
        repeat (260) @(posedge clk_i);
        chk_irq(1'b1);
        // split: low byte runs alone
        wb(1'b1, 8'h00, 8'h00);
        wb(1'b1, 8'h10, 8'h55);
        wb(1'b1, 8'h04, 8'hf0);
        wb(1'b1, 8'h0c, 8'hf0);
        wb(1'b1, 8'h00, 8'h08);
        repeat (40) @(posedge clk_i);
        rd(8'h00, 8'h48, 8'h00);
        rd(8'h10, 8'h55, 8'h00);
        rd(8'h0c, 8'hf8, 8'h08);
        chk_irq(1'b0);
        wb(1'b1, 8'h00, 8'h28);
        repeat (40) @(posedge clk_i);
        chk_irq(1'b1);
        // split: high byte on core clock, low byte slow
        wb(1'b1, 8'h14, 8'h20);
        wb(1'b1, 8'h0c, 8'h00);
        wb(1'b1, 8'h08, 8'h77);
        wb(1'b1, 8'h10, 8'hfe);
        wb(1'b1, 8'h00, 8'h0c);
        repeat (20) @(posedge clk_i);
        rd(8'h00, 8'h8c, 8'h00);
        // divided sources for both bytes
        wb(1'b1, 8'h14, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, 8'h00, 8'h0c | 8'(k));
            wb(1'b1, 8'h0c, 8'h00);
            wb(1'b1, 8'h10, 8'h00);
            repeat (800) @(posedge clk_i);
            rd(8'h0c, (k == 1) ? 8'd10 : 8'd67, 8'h02);
            rd(8'h10, (k == 1) ? 8'd10 : 8'd67, 8'h02);
        end
        repeat (4) @(posedge clk_i);
        end_of_test();
    end
endmodule
